// *** verilog/ceb_map.svh ***
// Opcode fields, data-space addresses and reset values of the execution core
// What this block does
// - Add/and/compare/subtract use accumulator plus memory or immediate
// - Clear/increment/decrement reach all 256 data bytes
// - Complement/rotate/shift act on accumulator only
// - ALU ops take four cycles; flag effects per op
// - Condition branches take two cycles, flags kept
// - Short branch spans -15 to +16 around itself
// - Bit-test branch: three bytes, five cycles, clear/set variants
// - Bit-test displacement spans -126 to +129
// - Bit-test copies tested bit into carry, zero kept
// - Bit set/clear: any bit, two bytes, four cycles
// - Control ops two cycles; only interrupt return changes flags
// - Watchdog selected turns stop into wait
// - Jump/call: 12-bit target, four cycles, call saves return
// - Short branch: condition, direction bit, four-bit span
// - Opcode bit 4 picks the index register
// - Long target is low opcode nibble plus next byte
// - Index and short registers sit at 80h-83h
`ifndef CEB_MAP_SVH
`define CEB_MAP_SVH
// Opcode groups, top three bits
`define CEB_GRP_BRNZ 3'h0
`define CEB_GRP_BRZ 3'h1
`define CEB_GRP_BRNC 3'h2
`define CEB_GRP_BRC 3'h3
`define CEB_GRP_EXT 3'h4
`define CEB_GRP_BIT 3'h5
`define CEB_GRP_ALU 3'h6
`define CEB_GRP_UNARY 3'h7
// Operand modes, opcode bits 3:2
`define CEB_MODE_IND 2'h0
`define CEB_MODE_DIR 2'h1
`define CEB_MODE_IMM 2'h2
`define CEB_MODE_INH 2'h3
// Two-operand ops, opcode bits 1:0
`define CEB_ALU_ADD 2'h0
`define CEB_ALU_AND 2'h1
`define CEB_ALU_CP 2'h2
`define CEB_ALU_SUB 2'h3
// Single-operand ops, opcode bits 1:0
`define CEB_UN_INC 2'h0
`define CEB_UN_DEC 2'h1
`define CEB_UN_CLR 2'h2
// Inherent ops, {opcode bit 4, bits 1:0}
`define CEB_INH_INV 3'h0
`define CEB_INH_ROTC 3'h1
`define CEB_INH_SHL 3'h2
`define CEB_INH_NOP 3'h3
`define CEB_INH_RET 3'h4
`define CEB_INH_IRET 3'h5
`define CEB_INH_STOP 3'h6
`define CEB_INH_WAIT 3'h7
// Bit ops, opcode bits 4:3
`define CEB_BIT_CLR 2'h0
`define CEB_BIT_SET 2'h1
`define CEB_BIT_TCLR 2'h2
`define CEB_BIT_TSET 2'h3
// Core registers in data space
`define CEB_ADDR_X 8'h80
`define CEB_ADDR_ACC 8'hFF
`define CEB_CORE_MASK 8'hFC
// Reset values and return stack
`define CEB_RESET_PC 12'h000
`define CEB_STACK_LAST 3'h5
`endif

// *** verilog/ceb_pkg.sv ***
// Types shared by the execution core and its return stack
package ceb_pkg;
  typedef enum logic [2:0] {
    S_OPC = 3'h0,
    S_BYTE2 = 3'h1,
    S_DATA = 3'h3,
    S_EXEC = 3'h2,
    S_FIN = 3'h6,
    S_HALT = 3'h4
  } ceb_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } ceb_dmem_req_t;
  typedef struct packed {
    logic z;
    logic c;
    logic [11:0] pc;
  } ceb_frame_t;
endpackage : ceb_pkg

// *** verilog/ceb_ret_stack.sv ***
// Six-entry return stack holding return address and flags
`timescale 1ns/1ps
`include "ceb_map.svh"
module ceb_ret_stack
  import ceb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic pop,
  input ceb_frame_t pushEnt,
  output ceb_frame_t topEnt
);
  ceb_frame_t entQ [0:5];
  ceb_frame_t entD [0:5];
  logic [2:0] ptrQ;
  logic [2:0] ptrD;
  logic [2:0] topIdx;

  // Pointer wraps on overflow, so the oldest return is silently lost
  always_comb begin
    ptrD = ptrQ;
    topIdx = (ptrQ == 3'h0) ? `CEB_STACK_LAST : ptrQ - 3'h1;
    if (push) begin
      ptrD = (ptrQ == `CEB_STACK_LAST) ? 3'h0 : ptrQ + 3'h1;
    end else if (pop) begin
      ptrD = topIdx;
    end
  end

  // One write port, entry picked by the pointer
  generate
    for (genvar i = 0; i < 6; i++) begin : gEnt
      always_comb begin
        entD[i] = (push && ptrQ == 3'(i)) ? pushEnt : entQ[i];
      end
    end
  endgenerate

  assign topEnt = entQ[topIdx];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ptrQ <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        entQ[i] <= '0;
      end
    end else begin
      ptrQ <= ptrD;
      entQ <= entD;
    end
  end
endmodule : ceb_ret_stack

// *** verilog/ceb_exec_core.sv ***
// Execution core for arithmetic, branch, bit, control and long jump ops
`timescale 1ns/1ps
`include "ceb_map.svh"
module ceb_exec_core
  import ceb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  output logic [11:0] pmAddr,
  input wire logic [7:0] pmData,
  output ceb_dmem_req_t dmReq,
  input wire logic [7:0] dmRdData,
  input wire logic wdogSel,
  input wire logic wakeReq,
  output logic waitMode,
  output logic stopMode
);
  ceb_state_t stateQ, stateD;
  logic [11:0] pcQ, pcD, pmAddrQ, pmAddrD, nextPc, newPc;
  logic [7:0] opQ, opD, b2Q, b2D, b3Q, b3D, accQ, accD;
  logic [7:0] regQ [0:3];
  logic [7:0] regD [0:3];
  logic zQ, zD, cQ, cD, takenQ, takenD, waitQ, waitD, stopQ, stopD;
  logic wdS1Q, wdS2Q, wkS1Q, wkS2Q;
  ceb_dmem_req_t dmQ, dmD;
  ceb_frame_t pushEnt, topEnt;
  logic push, pop, wr, bitVal;
  logic [7:0] rdByte, opnd, res;
  logic [8:0] sum, diff;
  logic [2:0] grp, inh;
  logic [1:0] mode, aop, bop;

  // Core registers answer in data space instead of external memory
  function automatic logic isCore(input logic [7:0] a);
    isCore = ((a & `CEB_CORE_MASK) == `CEB_ADDR_X) || (a == `CEB_ADDR_ACC);
  endfunction : isCore

  // Instruction length in bytes, used to step the program counter
  function automatic logic [11:0] byteLen(input logic [7:0] op);
    byteLen = 12'h001;
    case (op[7:5])
      `CEB_GRP_EXT: byteLen = 12'h002;
      `CEB_GRP_BIT: byteLen = op[4] ? 12'h003 : 12'h002;
      `CEB_GRP_ALU: begin
        if (op[3:2] == `CEB_MODE_DIR || op[3:2] == `CEB_MODE_IMM) begin
          byteLen = 12'h002;
        end
      end
      `CEB_GRP_UNARY: begin
        if (op[3:2] == `CEB_MODE_DIR) begin
          byteLen = (op[1:0] == `CEB_UN_CLR) ? 12'h003 : 12'h002;
        end else if (op[3:2] == `CEB_MODE_INH && {op[4], op[1:0]} == `CEB_INH_SHL) begin
          byteLen = 12'h002;
        end
      end
      default: byteLen = 12'h001;
    endcase
  endfunction : byteLen

  assign grp = opQ[7:5];
  assign mode = opQ[3:2];
  assign aop = opQ[1:0];
  assign bop = opQ[4:3];
  assign inh = {opQ[4], opQ[1:0]};
  assign pmAddr = pmAddrQ;
  assign dmReq = dmQ;
  assign waitMode = waitQ;
  assign stopMode = stopQ;

  ceb_ret_stack u_stack (
    .core_clk(core_clk),
    .resetn(resetn),
    .push(push),
    .pop(pop),
    .pushEnt(pushEnt),
    .topEnt(topEnt)
  );

  // Next-state logic; memory reads answer in the cycle of the address
  always_comb begin
    stateD = stateQ;
    pcD = pcQ;
    pmAddrD = pmAddrQ;
    opD = opQ;
    b2D = b2Q;
    b3D = b3Q;
    accD = accQ;
    regD = regQ;
    zD = zQ;
    cD = cQ;
    takenD = takenQ;
    waitD = waitQ;
    stopD = stopQ;
    dmD = dmQ;
    push = 1'b0;
    pop = 1'b0;
    wr = 1'b0;
    res = 8'h00;
    nextPc = pcQ + byteLen(opQ);
    newPc = nextPc;
    pushEnt = '{z: zQ, c: cQ, pc: nextPc};
    rdByte = !isCore(dmQ.addr) ? dmRdData :
             (dmQ.addr == `CEB_ADDR_ACC) ? accQ : regQ[dmQ.addr[1:0]];
    opnd = (mode == `CEB_MODE_IMM) ? b2Q : rdByte;
    sum = {1'b0, accQ} + {1'b0, opnd};
    diff = {1'b0, accQ} - {1'b0, opnd};
    bitVal = rdByte[opQ[2:0]];
    unique case (stateQ)
      S_OPC: begin
        opD = pmData;
        pmAddrD = pcQ + 12'h001;
        stateD = S_BYTE2;
      end
      S_BYTE2: begin
        b2D = pmData;
        pmAddrD = pcQ + 12'h002;
        // Indirect ops take the address from X or Y, chosen by bit 4
        dmD.addr = (mode == `CEB_MODE_IND && grp[2:1] == 2'b11) ?
                   regQ[{1'b0, opQ[4]}] : pmData;
        if (!grp[2]) begin
          // Condition branches finish here and keep both flags
          if ((grp == `CEB_GRP_BRNZ && !zQ) || (grp == `CEB_GRP_BRZ && zQ) ||
              (grp == `CEB_GRP_BRNC && !cQ) || (grp == `CEB_GRP_BRC && cQ)) begin
            pcD = opQ[4] ? pcQ - {8'h00, opQ[3:0]} :
                  pcQ + {8'h00, opQ[3:0]} + 12'h001;
          end else begin
            pcD = pcQ + 12'h001;
          end
          pmAddrD = pcD;
          stateD = S_OPC;
        end else if ((grp == `CEB_GRP_UNARY && mode == `CEB_MODE_INH && inh >= `CEB_INH_NOP) ||
                     (grp == `CEB_GRP_UNARY && mode != `CEB_MODE_INH && aop == 2'h3) ||
                     (grp == `CEB_GRP_ALU && mode == `CEB_MODE_INH)) begin
          // Control ops and spare codes run as two-cycle ops
          pcD = pcQ + 12'h001;
          if (grp == `CEB_GRP_UNARY && mode == `CEB_MODE_INH) begin
            if (inh == `CEB_INH_RET || inh == `CEB_INH_IRET) begin
              pop = 1'b1;
              pcD = topEnt.pc;
              if (inh == `CEB_INH_IRET) begin
                zD = topEnt.z;
                cD = topEnt.c;
              end
            end else if (inh == `CEB_INH_STOP || inh == `CEB_INH_WAIT) begin
              stopD = (inh == `CEB_INH_STOP) && !wdS2Q;
              waitD = !stopD;
              stateD = S_HALT;
            end
          end
          pmAddrD = pcD;
          if (stateD != S_HALT) begin
            stateD = S_OPC;
          end
        end else begin
          stateD = S_DATA;
        end
      end
      S_DATA: begin
        b3D = pmData;
        stateD = S_EXEC;
        if (grp == `CEB_GRP_ALU) begin
          unique case (aop)
            `CEB_ALU_ADD: {cD, res} = sum;
            `CEB_ALU_AND: begin
              res = accQ & opnd;
              cD = 1'b0;
            end
            default: {cD, res} = diff; // Carry holds the borrow
          endcase
          zD = (res == 8'h00);
          if (aop != `CEB_ALU_CP) begin
            accD = res;
          end
        end else if (grp == `CEB_GRP_UNARY && mode == `CEB_MODE_INH) begin
          cD = accQ[7];
          unique case (inh)
            `CEB_INH_INV: res = ~accQ;
            `CEB_INH_ROTC: res = {accQ[6:0], cQ};
            default: res = {accQ[6:0], 1'b0};
          endcase
          zD = (res == 8'h00);
          accD = res;
        end else if (grp == `CEB_GRP_UNARY) begin
          // Carry is untouched, clear also leaves zero alone
          wr = 1'b1;
          unique case (aop)
            `CEB_UN_INC: res = rdByte + 8'h01;
            `CEB_UN_DEC: res = rdByte - 8'h01;
            default: res = 8'h00;
          endcase
          if (aop != `CEB_UN_CLR) begin
            zD = (res == 8'h00);
          end
        end else if (grp == `CEB_GRP_BIT) begin
          res = rdByte;
          if (!bop[1]) begin
            // Read-modify-write rewrites the whole byte
            res[opQ[2:0]] = bop[0];
            wr = 1'b1;
          end else begin
            cD = bitVal;
            takenD = (bitVal == bop[0]);
          end
        end
        dmD.wdata = res;
        if (wr && isCore(dmQ.addr)) begin
          if (dmQ.addr == `CEB_ADDR_ACC) begin
            accD = res;
          end else begin
            regD[dmQ.addr[1:0]] = res;
          end
        end else begin
          dmD.we = wr;
        end
      end
      S_EXEC: begin
        dmD.we = 1'b0;
        if (grp == `CEB_GRP_BIT && bop[1]) begin
          stateD = S_FIN;
        end else begin
          if (grp == `CEB_GRP_EXT) begin
            newPc = {opQ[3:0], b2Q};
            push = !opQ[4];
          end
          pcD = newPc;
          pmAddrD = newPc;
          stateD = S_OPC;
        end
      end
      S_FIN: begin
        pcD = takenQ ? pcQ + 12'h002 + {{4{b3Q[7]}}, b3Q} : nextPc;
        pmAddrD = pcD;
        stateD = S_OPC;
      end
      S_HALT: begin
        // Wake input is asynchronous, so only its synchronised copy is used
        if (wkS2Q) begin
          waitD = 1'b0;
          stopD = 1'b0;
          stateD = S_OPC;
        end
      end
      default: stateD = S_OPC;
    endcase
  end

  // State registers; pin inputs pass two flops before use
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= S_OPC;
      pcQ <= `CEB_RESET_PC;
      pmAddrQ <= `CEB_RESET_PC;
      opQ <= 8'h00;
      b2Q <= 8'h00;
      b3Q <= 8'h00;
      accQ <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        regQ[i] <= 8'h00;
      end
      zQ <= 1'b0;
      cQ <= 1'b0;
      takenQ <= 1'b0;
      waitQ <= 1'b0;
      stopQ <= 1'b0;
      dmQ <= '0;
      wdS1Q <= 1'b0;
      wdS2Q <= 1'b0;
      wkS1Q <= 1'b0;
      wkS2Q <= 1'b0;
    end else begin
      stateQ <= stateD;
      pcQ <= pcD;
      pmAddrQ <= pmAddrD;
      opQ <= opD;
      b2Q <= b2D;
      b3Q <= b3D;
      accQ <= accD;
      regQ <= regD;
      zQ <= zD;
      cQ <= cD;
      takenQ <= takenD;
      waitQ <= waitD;
      stopQ <= stopD;
      dmQ <= dmD;
      wdS1Q <= wdogSel;
      wdS2Q <= wdS1Q;
      wkS1Q <= wakeReq;
      wkS2Q <= wkS1Q;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_BRANCH_TWO: assert property (
    (stateQ == S_BYTE2 && !grp[2]) |=> stateQ == S_OPC && $stable(zQ) && $stable(cQ))
    else $error("condition branch not done in two cycles or flags moved");
  AST_ALU_FOUR: assert property (
    (stateQ == S_BYTE2 && grp == `CEB_GRP_ALU && mode != `CEB_MODE_INH)
    |=> stateQ == S_DATA ##1 stateQ == S_EXEC ##1 stateQ == S_OPC)
    else $error("arithmetic op not done in four cycles");
  AST_BTB_FIVE: assert property (
    (stateQ == S_BYTE2 && grp == `CEB_GRP_BIT && bop[1]) |-> ##4 stateQ == S_OPC)
    else $error("bit-test branch not done in five cycles");
  AST_BTB_CARRY: assert property (
    (stateQ == S_DATA && grp == `CEB_GRP_BIT && bop[1])
    |=> cQ == $past(bitVal) && zQ == $past(zQ))
    else $error("tested bit not copied to carry");
  AST_INC_KEEPS_C: assert property (
    (stateQ == S_DATA && grp == `CEB_GRP_UNARY && mode != `CEB_MODE_INH)
    |=> $stable(cQ))
    else $error("increment or decrement changed carry");
  AST_STOP_WDOG: assert property (
    (stateQ == S_BYTE2 && grp == `CEB_GRP_UNARY && mode == `CEB_MODE_INH &&
     inh == `CEB_INH_STOP && wdS2Q) |=> waitQ && !stopQ && stateQ == S_HALT)
    else $error("stop not turned into wait under watchdog");
  AST_JUMP_TARGET: assert property (
    (stateQ == S_EXEC && grp == `CEB_GRP_EXT)
    |=> pcQ == {$past(opQ[3:0]), $past(b2Q)} && pmAddrQ == pcQ)
    else $error("long target not formed from nibble and byte");
  AST_BITOP_WRITE: assert property (
    (stateQ == S_DATA && grp == `CEB_GRP_BIT && !bop[1])
    |=> dmQ.wdata[$past(opQ[2:0])] == $past(bop[0]) ##1 stateQ == S_OPC)
    else $error("bit set or clear wrote the wrong value");
  AST_REL_FWD: assert property (
    (stateQ == S_BYTE2 && grp == `CEB_GRP_BRC && cQ && !opQ[4])
    |=> pcQ == $past(pcQ) + {8'h00, $past(opQ[3:0])} + 12'h001)
    else $error("forward short branch target wrong");
endmodule : ceb_exec_core

// *** bench/ceb_mem_model.sv ***
// Program memory and data-space memory facing the execution core
`timescale 1ns/1ps
module ceb_mem_model
  import ceb_pkg::*;
(
  input wire logic core_clk,
  input wire logic [11:0] pmAddr,
  output logic [7:0] pmData,
  input ceb_dmem_req_t dmReq,
  output logic [7:0] dmRdData
);
  logic [7:0] pm [4096];
  logic [7:0] dm [256];

  // Both reads answer in the same cycle, as the core expects
  assign pmData = pm[pmAddr];
  assign dmRdData = dm[dmReq.addr];

  // Writes land on the edge that ends the strobe cycle
  always @(posedge core_clk) begin
    if (dmReq.we === 1'b1) begin
      dm[dmReq.addr] <= dmReq.wdata;
    end
  end
endmodule : ceb_mem_model

// *** bench/tb_top.sv ***
// Self-checking bench for the execution core
`timescale 1ns/1ps
module tb_top;
  import ceb_pkg::*;
  localparam logic [11:0] LAND_G = 12'h7A0;
  localparam logic [11:0] LAND_B = 12'h5B0;
  logic core_clk;
  logic resetn;
  logic wdogSel;
  logic wakeReq;
  logic [11:0] pmAddr;
  logic [7:0] pmData;
  ceb_dmem_req_t dmReq;
  logic [7:0] dmRdData;
  logic waitMode;
  logic stopMode;
  int errors;
  int n_tests;

  ceb_exec_core dut (
    .core_clk(core_clk),
    .resetn(resetn),
    .pmAddr(pmAddr),
    .pmData(pmData),
    .dmReq(dmReq),
    .dmRdData(dmRdData),
    .wdogSel(wdogSel),
    .wakeReq(wakeReq),
    .waitMode(waitMode),
    .stopMode(stopMode)
  );

  ceb_mem_model mem (
    .core_clk(core_clk),
    .pmAddr(pmAddr),
    .pmData(pmData),
    .dmReq(dmReq),
    .dmRdData(dmRdData)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task automatic ld(input logic [11:0] a, input logic [7:0] q[$]);
    foreach (q[i]) begin
      mem.pm[a + 12'(i)] = q[i];
    end
  endtask : ld

  // Long jump, target split as low opcode nibble and next byte
  task automatic jp(input logic [11:0] a, input logic [11:0] t);
    ld(a, '{{4'h9, t[11:8]}, t[7:0]});
  endtask : jp

  // Hold reset while both memories are refilled; spare program bytes are no-ops
  task automatic prep();
    @(posedge core_clk);
    resetn <= 1'b0;
    for (int i = 0; i < 4096; i++) begin
      mem.pm[i] = 8'hEF;
    end
    for (int i = 0; i < 256; i++) begin
      mem.dm[i] = ~8'(i);
    end
    repeat (2) @(posedge core_clk);
  endtask : prep

  // Bounded wait until the core fetches from one of the two exits
  task automatic land(output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (pmAddr !== LAND_G && pmAddr !== LAND_B && k < 300);
    if (k >= 300) begin
      errors++;
      summarize();
    end
  endtask : land

  // Release reset and judge both exit and cycle count from the first fetch
  task automatic go(input logic [11:0] exp, input int cyc);
    int k;
    @(posedge core_clk);
    resetn <= 1'b1;
    land(k);
    check(16'(pmAddr), 16'(exp));
    check(16'(k), 16'(cyc));
  endtask : go

  // Load A by an add to zero, apply one op, then read the flags with one branch
  task automatic brcase(input logic [7:0] p, input logic [7:0] op, input logic [7:0] b2,
                        input logic [2:0] cond, input logic [11:0] exp, input int cyc);
    prep();
    ld(12'h000, '{8'hC8, p, op, b2, {cond, 5'h02}});
    jp(12'h005, LAND_B);
    jp(12'h007, LAND_G);
    go(exp, cyc);
  endtask : brcase

  // Short branch from 020h to its far ends
  task automatic span_case(input logic [7:0] br, input logic [11:0] tgt);
    prep();
    jp(12'h000, 12'h020);
    ld(12'h020, '{br});
    jp(12'h021, LAND_B);
    jp(tgt, LAND_G);
    go(LAND_G, 10);
  endtask : span_case

  // Call 345h, set Z there, return; Z seen afterwards tells which return ran
  task automatic ret_case(input logic [7:0] op, input logic [11:0] exp);
    prep();
    ld(12'h000, '{8'h83, 8'h45, 8'h22});
    jp(12'h003, LAND_G);
    jp(12'h005, LAND_B);
    ld(12'h345, '{8'hC8, 8'h00, op});
    go(exp, 16);
  endtask : ret_case

  // Bit ops on a RAM byte only
  task automatic bit_case();
    prep();
    mem.dm[8'h40] = 8'h5A;
    ld(12'h000, '{8'hA8, 8'h40, 8'hA6, 8'h40, 8'hE4, 8'hFE, 8'hE5, 8'h00, 8'hBC, 8'h40, 8'h7F});
    jp(12'h00B, LAND_B);
    ld(12'h089, '{8'h62});
    jp(12'h08A, LAND_B);
    ld(12'h08C, '{8'hB2, 8'h40, 8'h80});
    jp(12'h08F, LAND_B);
    ld(12'h00E, '{8'h42});
    jp(12'h00F, LAND_B);
    jp(12'h011, LAND_G);
    go(LAND_G, 34);
    check(16'(mem.dm[8'h40]), 16'h001B);
    check(16'(mem.dm[8'hFE]), 16'h0002);
    check(16'(mem.dm[8'h00]), 16'h00FE);
  endtask : bit_case

  // Index registers set by direct increments, then used for indirect increments
  task automatic index_case();
    prep();
    ld(12'h000, '{8'hE4, 8'h80, 8'hE4, 8'h81, 8'hE4, 8'h81, 8'hE0, 8'hF0});
    // Three-byte clear of a RAM byte, last byte skipped
    ld(12'h008, '{8'hE6, 8'h30, 8'h00});
    jp(12'h00B, LAND_G);
    go(LAND_G, 28);
    check(16'(mem.dm[8'h30]), 16'h0000);
    check(16'(mem.dm[8'h01]), 16'h00FF);
    check(16'(mem.dm[8'h02]), 16'h00FE);
    check(16'({mem.dm[8'h80], mem.dm[8'h81]}), 16'h7F7E);
  endtask : index_case

  // Halt, stay halted without wake, then leave on wake
  task automatic halt_case(input logic sel, input logic [7:0] op, input logic [1:0] mode);
    int k;
    prep();
    wdogSel <= sel;
    ld(12'h000, '{8'hEF, 8'hEF, op});
    jp(12'h003, LAND_G);
    @(posedge core_clk);
    resetn <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    check(16'({waitMode, stopMode}), 16'(mode));
    check(16'(pmAddr == LAND_G), 16'h0000);
    @(posedge core_clk);
    wakeReq <= 1'b1;
    land(k);
    // Judged at the landing fetch, before the core moves past it
    check(16'(pmAddr), 16'(LAND_G));
    check(16'({waitMode, stopMode}), 16'h0000);
    check(16'(k), 16'h0007);
    @(posedge core_clk);
    wakeReq <= 1'b0;
  endtask : halt_case

  // Main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    resetn = 1'b0;
    wdogSel = 1'b0;
    wakeReq = 1'b0;
    repeat (16) @(posedge core_clk);
    brcase(8'hFF, 8'hC8, 8'h01, 3'h3, LAND_G, 14);
    brcase(8'hFF, 8'hC8, 8'h01, 3'h1, LAND_G, 14);
    brcase(8'hFF, 8'hC8, 8'h01, 3'h2, LAND_B, 14);
    brcase(8'hFF, 8'hC8, 8'h01, 3'h0, LAND_B, 14);
    brcase(8'hFF, 8'hC9, 8'h0F, 3'h2, LAND_G, 14);
    brcase(8'hFF, 8'hC9, 8'h0F, 3'h1, LAND_B, 14);
    brcase(8'h05, 8'hCA, 8'h05, 3'h1, LAND_G, 14);
    brcase(8'h05, 8'hCA, 8'h05, 3'h3, LAND_B, 14);
    brcase(8'h01, 8'hCB, 8'h02, 3'h3, LAND_G, 14);
    brcase(8'h01, 8'hCB, 8'h02, 3'h1, LAND_B, 14);
    brcase(8'h00, 8'hC4, 8'h40, 3'h0, LAND_G, 14);
    brcase(8'h01, 8'hC0, 8'hEF, 3'h1, LAND_G, 16);
    brcase(8'hFF, 8'hEC, 8'hEF, 3'h3, LAND_G, 16);
    brcase(8'h80, 8'hED, 8'hEF, 3'h1, LAND_G, 16);
    brcase(8'h40, 8'hEE, 8'h00, 3'h0, LAND_G, 14);
    brcase(8'h00, 8'hEF, 8'hEF, 3'h1, LAND_G, 14);
    span_case(8'h5F, 12'h011);
    span_case(8'h4F, 12'h030);
    ret_case(8'hFD, LAND_G);
    ret_case(8'hFC, LAND_B);
    bit_case();
    index_case();
    halt_case(1'b0, 8'hFF, 2'h2);
    halt_case(1'b0, 8'hFE, 2'h1);
    halt_case(1'b1, 8'hFE, 2'h2);
    summarize();
  end
endmodule : tb_top
